// ==== hdl/dcd_regs.svh ====
`ifndef DCD_REGS_SVH
`define DCD_REGS_SVH
`define DCD_BANKS        8
`define DCD_BANK_W       3
`define DCD_ADDR_W       13
`define DCD_COL_W        10
`define DCD_PIN_W        16
`define DCD_WORD_W       128
`define DCD_BEATS_BL8    4'h8
`define DCD_BEATS_BC4    4'h4
`define DCD_AP_BIT       10
`define DCD_BC_BIT       12
`define DCD_BT_BIT       3
`define DCD_BL_LO        0
`define DCD_BL_FIXED8    2'h0
`define DCD_BL_OTF       2'h1
`define DCD_BL_FIXED4    2'h2
`define DCD_MR0          3'h0
`define DCD_LANE_LO_MSB  7
`define DCD_LANE_HI_LSB  8
`endif

// ==== hdl/dcd_pkg.sv ====
package dcd_pkg;
	`include "dcd_regs.svh"
	typedef enum logic [3:0] {
		DCD_CMD_NONE, DCD_CMD_ACT, DCD_CMD_PRE, DCD_CMD_PREA, DCD_CMD_WR, DCD_CMD_RD,
		DCD_CMD_MRS, DCD_CMD_NOP, DCD_CMD_DES, DCD_CMD_REF, DCD_CMD_SRE, DCD_CMD_SRX,
		DCD_CMD_PDE, DCD_CMD_PDX, DCD_CMD_ZQL, DCD_CMD_ZQS
	} dcd_cmd_t;
	typedef enum logic [1:0] {DCD_PM_ON, DCD_PM_PDN, DCD_PM_SREF} dcd_pm_t;
	typedef struct packed {
		logic                     cs_n;
		logic                     ras_n;
		logic                     cas_n;
		logic                     we_n;
		logic                     cke;
		logic [`DCD_BANK_W-1:0]   bank;
		logic [`DCD_ADDR_W-1:0]   addr;
	} dcd_cmd_bus_t;
	typedef struct packed {
		dcd_cmd_t                 cmd;
		logic [`DCD_BANK_W-1:0]   bank;
		logic [`DCD_ADDR_W-1:0]   row;
		logic [`DCD_COL_W-1:0]    col;
		logic                     auto_pre;
		logic                     chop4;
		logic                     zq_long;
		logic                     illegal;
	} dcd_decoded_t;
endpackage

// ==== hdl/dcd_burst.sv ====
`timescale 1ns/1ps
`include "dcd_regs.svh"
module dcd_burst (
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire logic                    start,
	input  wire logic                    is_write,
	input  wire logic                    chop4,
	input  wire logic                    interleave,
	input  wire logic [`DCD_COL_W-1:0]   col,
	input  wire logic [`DCD_PIN_W-1:0]   wr_beat,
	input  wire logic                    lower_byte_write_mask,
	input  wire logic                    upper_byte_write_mask,
	input  wire logic [`DCD_WORD_W-1:0]  rd_word,
	output logic                         busy,
	output logic [`DCD_COL_W-1:0]        beat_col,
	output logic [`DCD_PIN_W-1:0]        rd_beat,
	output logic [`DCD_WORD_W-1:0]       wr_word,
	output logic [`DCD_WORD_W/8-1:0]     wr_byte_en,
	output logic                         word_done
);
	import dcd_pkg::*;
	typedef struct packed {
		logic                        busy;
		logic                        wr;
		logic                        ilv;
		logic [3:0]                  len;
		logic [3:0]                  idx;
		logic [`DCD_COL_W-1:0]       col;
		logic [`DCD_COL_W-1:0]       beat_col;
		logic [`DCD_PIN_W-1:0]       rd_beat;
		logic [`DCD_WORD_W-1:0]      wr_word;
		logic [`DCD_WORD_W/8-1:0]    wr_be;
		logic                        done;
	} dcd_burst_st_t;
	dcd_burst_st_t st, next_st;
	// Burst order of low three column bits
	function automatic logic [2:0] beat_order(input logic [2:0] start_lo, input logic [2:0] i,
		input logic ilv);
		beat_order = ilv ? (start_lo ^ i) : (start_lo + i);
	endfunction
	always_comb begin
		logic [2:0] slot;
		slot = st.idx[2:0];
		next_st = st;
		next_st.done = 1'b0;
		if (start && !st.busy) begin
			next_st.busy = 1'b1;
			next_st.wr = is_write;
			next_st.ilv = interleave;
			next_st.col = col;
			next_st.idx = 4'h0;
			next_st.len = chop4 ? `DCD_BEATS_BC4 : `DCD_BEATS_BL8;
			next_st.wr_be = '0;
		end else if (st.busy) begin
			next_st.beat_col = {st.col[`DCD_COL_W-1:3], beat_order(st.col[2:0], slot, st.ilv)};
			// Two pin beats per clock on the pins map to one beat per mclk here
			if (st.wr) begin
				if (!lower_byte_write_mask) begin
					next_st.wr_word[slot*`DCD_PIN_W +: 8] = wr_beat[`DCD_LANE_LO_MSB:0];
					next_st.wr_be[slot*2] = 1'b1;
				end
				if (!upper_byte_write_mask) begin
					next_st.wr_word[slot*`DCD_PIN_W+`DCD_LANE_HI_LSB +: 8] =
						wr_beat[`DCD_PIN_W-1:`DCD_LANE_HI_LSB];
					next_st.wr_be[slot*2+1] = 1'b1;
				end
			end else begin
				next_st.rd_beat = rd_word[slot*`DCD_PIN_W +: `DCD_PIN_W];
			end
			next_st.idx = st.idx + 4'h1;
			if (st.idx + 4'h1 == st.len) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1; // One 8n word per access
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign busy = st.busy;
	assign beat_col = st.beat_col;
	assign rd_beat = st.rd_beat;
	assign wr_word = st.wr_word;
	assign wr_byte_en = st.wr_be;
	assign word_done = st.done;
endmodule

// ==== hdl/dcd_core.sv ====
`timescale 1ns/1ps
`include "dcd_regs.svh"
// Functional notes
// - Activate opens row on selected bank
// - Write decoded to an active bank
// - Read decoded only to an active bank
// - On-the-fly chop bit picks four or eight
// - Auto-precharge bit closes bank after burst
// - Mode set only when all idle
// - Enable falling with no-op enters power-down
// - Enable rising with no-op exits power-down
// - High mask suppresses its byte independently
// - Lower mask bits 0-7, upper 8-15
// - Clock enable decoded from two samples
// - State tracked per selected bank
// - Eight pin beats form one word
// - Bursts of eight or four in sequential or interleaved order
module dcd_core (
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	input  wire dcd_pkg::dcd_cmd_bus_t    cmd_in,
	input  wire logic [`DCD_PIN_W-1:0]    wr_beat,
	input  wire logic                     lower_byte_write_mask,
	input  wire logic                     upper_byte_write_mask,
	input  wire logic [`DCD_WORD_W-1:0]   rd_word,
	output dcd_pkg::dcd_decoded_t         decoded,
	output logic [`DCD_BANKS-1:0]         bank_open,
	output dcd_pkg::dcd_pm_t              power_mode,
	output logic [`DCD_ADDR_W-1:0]        mode_reg0,
	output logic [`DCD_COL_W-1:0]         beat_col,
	output logic [`DCD_PIN_W-1:0]         rd_beat,
	output logic [`DCD_WORD_W-1:0]        wr_word,
	output logic [`DCD_WORD_W/8-1:0]      wr_byte_en,
	output logic                          word_done
);
	import dcd_pkg::*;
	typedef struct packed {
		logic                            cke_prev;
		logic [`DCD_BANKS-1:0]           open;
		logic [`DCD_BANKS-1:0]           ap_pend;
		logic [`DCD_BANK_W-1:0]          ap_bank;
		dcd_pm_t                         pm;
		logic [`DCD_ADDR_W-1:0]          mr0;
		dcd_decoded_t                    dec;
	} dcd_st_t;
	dcd_st_t st, next_st;
	logic burst_busy;
	logic burst_done;
	logic burst_start;
	logic burst_wr;
	logic [`DCD_BANKS-1:0] ap_closing;
	genvar gb;
	// Shared between decode and bank bookkeeping
	function automatic logic [`DCD_BANKS-1:0] bank_bit(input logic [`DCD_BANK_W-1:0] b);
		bank_bit = '0;
		bank_bit[b] = 1'b1;
	endfunction
	// Deselect or no-op, the only inputs legal on a clock enable rise; a fall also takes refresh
	function automatic logic is_nop_like(input dcd_cmd_bus_t c);
		is_nop_like = c.cs_n || ({c.ras_n, c.cas_n, c.we_n} == 3'h7);
	endfunction
	// Bank whose auto-precharge burst ends now counts as closed this cycle
	generate
		for (gb = 0; gb < `DCD_BANKS; gb++) begin : g_ap_close
			assign ap_closing[gb] = burst_done && st.ap_pend[gb] && (st.ap_bank == `DCD_BANK_W'(gb));
		end
	endgenerate
	always_comb begin
		logic nop_like;
		logic sel_open;
		logic all_idle;
		logic [3:0] pins;
		logic chop;
		nop_like = is_nop_like(cmd_in);
		sel_open = st.open[cmd_in.bank] && !ap_closing[cmd_in.bank];
		// A running burst counts as busy, so mode set and refresh are refused during it
		all_idle = (st.open == '0) && !burst_busy;
		pins = {cmd_in.cs_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
		chop = (st.mr0[`DCD_BL_LO +: 2] == `DCD_BL_FIXED4) ||
			((st.mr0[`DCD_BL_LO +: 2] == `DCD_BL_OTF) && !cmd_in.addr[`DCD_BC_BIT]);
		next_st = st;
		next_st.cke_prev = cmd_in.cke;
		next_st.dec = '0;
		next_st.dec.cmd = DCD_CMD_NONE;
		next_st.dec.bank = cmd_in.bank;
		next_st.dec.row = cmd_in.addr;
		next_st.dec.col = cmd_in.addr[`DCD_COL_W-1:0];
		next_st.dec.auto_pre = cmd_in.addr[`DCD_AP_BIT];
		next_st.dec.chop4 = chop;
		next_st.dec.zq_long = cmd_in.addr[`DCD_AP_BIT];
		burst_start = 1'b0;
		burst_wr = 1'b0;
		// Auto-precharge closes the bank once its burst word completes
		next_st.open = st.open & ~ap_closing;
		next_st.ap_pend = st.ap_pend & ~ap_closing;
		if (st.cke_prev && !cmd_in.cke) begin
			// Self-refresh needs every bank idle; otherwise the entry is refused
			if (!cmd_in.cs_n && pins == 4'h1 && all_idle) begin
				next_st.dec.cmd = DCD_CMD_SRE;
				next_st.pm = DCD_PM_SREF;
			end else if (nop_like) begin
				next_st.dec.cmd = DCD_CMD_PDE;
				next_st.pm = DCD_PM_PDN;
			end else begin
				next_st.dec.illegal = 1'b1;
			end
		end else if (!st.cke_prev && cmd_in.cke) begin
			if (nop_like) begin
				next_st.dec.cmd = (st.pm == DCD_PM_SREF) ? DCD_CMD_SRX : DCD_CMD_PDX;
				next_st.pm = DCD_PM_ON;
			end else begin
				next_st.dec.illegal = 1'b1;
			end
		end else if (st.cke_prev && cmd_in.cke) begin
			if (cmd_in.cs_n) begin
				next_st.dec.cmd = DCD_CMD_DES;
			end else begin
				case (pins)
					4'h3: begin
						// Closed bank only; an open row must be precharged first
						next_st.dec.cmd = DCD_CMD_ACT;
						next_st.dec.illegal = sel_open;
						if (!sel_open) begin
							next_st.open = next_st.open | bank_bit(cmd_in.bank);
						end
					end
					4'h2: begin
						// Legal in any bank state
						if (cmd_in.addr[`DCD_AP_BIT]) begin
							next_st.dec.cmd = DCD_CMD_PREA;
							next_st.open = '0;
							// Pending auto-precharge dropped so a reopened row stays open
							next_st.ap_pend = '0;
						end else begin
							next_st.dec.cmd = DCD_CMD_PRE;
							next_st.open = next_st.open & ~bank_bit(cmd_in.bank);
							next_st.ap_pend = next_st.ap_pend & ~bank_bit(cmd_in.bank);
						end
					end
					4'h4, 4'h5: begin
						next_st.dec.cmd = (pins == 4'h4) ? DCD_CMD_WR : DCD_CMD_RD;
						// Reject when bank closed or burst engine busy; no queueing
						if (!sel_open || burst_busy) begin
							next_st.dec.illegal = 1'b1;
						end else begin
							burst_start = 1'b1;
							burst_wr = (pins == 4'h4);
							if (cmd_in.addr[`DCD_AP_BIT]) begin
								next_st.ap_pend[cmd_in.bank] = 1'b1;
								next_st.ap_bank = cmd_in.bank;
							end
						end
					end
					4'h0: begin
						next_st.dec.cmd = DCD_CMD_MRS;
						next_st.dec.illegal = !all_idle;
						// Only the first mode register is kept; the others are dropped
						if (all_idle && cmd_in.bank == `DCD_MR0) begin
							next_st.mr0 = cmd_in.addr;
						end
					end
					4'h1: begin
						next_st.dec.cmd = DCD_CMD_REF;
						next_st.dec.illegal = !all_idle;
					end
					4'h6: begin
						next_st.dec.cmd = cmd_in.addr[`DCD_AP_BIT] ? DCD_CMD_ZQL : DCD_CMD_ZQS;
						next_st.dec.illegal = !all_idle;
					end
					4'h7: begin
						next_st.dec.cmd = DCD_CMD_NOP;
					end
					default: begin
						next_st.dec.cmd = DCD_CMD_NONE;
					end
				endcase
			end
		end else begin
			// Both samples low: held powered down, inputs ignored
			next_st.dec.cmd = DCD_CMD_NONE;
		end
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	// Chop choice taken from this cycle's decode so it matches the command
	dcd_burst u_burst (
		.mclk                  (mclk),
		.rst_n                 (rst_n),
		.start                 (burst_start),
		.is_write              (burst_wr),
		.chop4                 (next_st.dec.chop4),
		.interleave            (st.mr0[`DCD_BT_BIT]),
		.col                   (cmd_in.addr[`DCD_COL_W-1:0]),
		.wr_beat               (wr_beat),
		.lower_byte_write_mask (lower_byte_write_mask),
		.upper_byte_write_mask (upper_byte_write_mask),
		.rd_word               (rd_word),
		.busy                  (burst_busy),
		.beat_col              (beat_col),
		.rd_beat               (rd_beat),
		.wr_word               (wr_word),
		.wr_byte_en            (wr_byte_en),
		.word_done             (burst_done)
	);
	assign decoded = st.dec;
	assign bank_open = st.open;
	assign power_mode = st.pm;
	assign mode_reg0 = st.mr0;
	assign word_done = burst_done;
endmodule

// ==== verification/dcd_ctrl_model.sv ====
`timescale 1ns/1ps
module dcd_ctrl_model (
	input  wire dcd_pkg::dcd_cmd_t      kind,
	input  wire logic                   cke,
	input  wire logic [2:0]             bank,
	input  wire logic [12:0]            addr,
	output dcd_pkg::dcd_cmd_bus_t       bus
);
	import dcd_pkg::*;
	logic [3:0] s;
	// Strobes cs ras cas we
	always_comb begin
		case (kind)
			DCD_CMD_ACT: s = 4'h3;
			DCD_CMD_PRE: s = 4'h2;
			DCD_CMD_WR:  s = 4'h4;
			DCD_CMD_RD:  s = 4'h5;
			DCD_CMD_MRS: s = 4'h0;
			DCD_CMD_REF: s = 4'h1;
			DCD_CMD_ZQL: s = 4'h6;
			// Others low so an ignored strobe would look like a mode set
			DCD_CMD_DES: s = 4'h8;
			default:     s = 4'h7;
		endcase
	end
	assign bus = {s, cke, bank, addr};
endmodule

// ==== verification/dcd_core_asserts.sv ====
`timescale 1ns/1ps
module dcd_core_asserts (
	input wire logic                    mclk,
	input wire logic                    rst_n,
	input wire dcd_pkg::dcd_cmd_bus_t   cmd_in,
	input wire dcd_pkg::dcd_decoded_t   decoded,
	input wire logic [7:0]              bank_open,
	input wire dcd_pkg::dcd_pm_t        power_mode,
	input wire logic [12:0]             mode_reg0,
	input wire logic                    word_done
);
	import dcd_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire ok = !decoded.illegal;
	wire acc = decoded.cmd inside {DCD_CMD_WR, DCD_CMD_RD};
	wire rd_pat = !cmd_in.cs_n && cmd_in.ras_n && !cmd_in.cas_n && cmd_in.we_n;
	sequence bl8_done; ##8 word_done; endsequence
	sequence bc4_done; ##4 word_done; endsequence
	act_opens_a: assert property (
		decoded.cmd == DCD_CMD_ACT && ok |-> bank_open[decoded.bank])
		else $error("activate left bank closed");
	prea_closes_a: assert property (
		decoded.cmd == DCD_CMD_PREA |-> bank_open == 8'h00)
		else $error("banks open after precharge all");
	rd_refused_a: assert property (
		$past(rst_n) && rd_pat && cmd_in.cke && $past(cmd_in.cke)
		&& !bank_open[cmd_in.bank] |=> decoded.illegal) else $error("read to closed bank");
	mrs_load_a: assert property (
		decoded.cmd == DCD_CMD_MRS && ok && decoded.bank == 3'h0
		|-> mode_reg0 == $past(cmd_in.addr)) else $error("mode word not loaded");
	zq_kind_a: assert property (
		decoded.cmd inside {DCD_CMD_ZQL, DCD_CMD_ZQS} && ok
		|-> decoded.zq_long == $past(cmd_in.addr[10])
		&& (decoded.cmd == DCD_CMD_ZQL) == $past(cmd_in.addr[10])) else $error("zq kind");
	bl8_len_a: assert property (
		acc && ok && !decoded.chop4 |-> bl8_done) else $error("eight beat burst length");
	bc4_len_a: assert property (
		acc && ok && decoded.chop4 |-> bc4_done) else $error("chopped burst length");
	pde_cause_a: assert property (
		power_mode == DCD_PM_PDN && $past(power_mode) == DCD_PM_ON
		|-> !$past(cmd_in.cke) && $past(cmd_in.cke, 2)) else $error("power-down cause");
	pdx_cause_a: assert property (
		$past(power_mode) == DCD_PM_PDN && power_mode == DCD_PM_ON
		|-> $past(cmd_in.cke)) else $error("power-down exit cause");
	sre_cause_a: assert property (
		power_mode == DCD_PM_SREF && $past(power_mode) == DCD_PM_ON
		|-> !$past(cmd_in.cke) && !$past(cmd_in.ras_n)) else $error("self-refresh cause");
endmodule
bind dcd_core dcd_core_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .cmd_in(cmd_in),
	.decoded(decoded), .bank_open(bank_open), .power_mode(power_mode),
	.mode_reg0(mode_reg0), .word_done(word_done));

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module testbench;
	import dcd_pkg::*;
	logic                  mclk = 0;
	logic                  rst_n = 0;
	logic                  cke = 1;
	logic                  lower_byte_write_mask = 0;
	logic                  upper_byte_write_mask = 0;
	dcd_cmd_t              kind = DCD_CMD_NOP;
	logic [2:0]            bank = 0;
	logic [12:0]           addr = 0;
	logic [15:0]           wr_beat = 0;
	logic [127:0]          rd_word = 0;
	dcd_cmd_bus_t          bus;
	dcd_decoded_t          dec;
	dcd_pm_t               pm;
	logic [7:0]            bank_open;
	logic [12:0]           mr0;
	logic [15:0]           rd_beat;
	logic [9:0]            beat_col;
	logic [15:0]           wr_be;
	logic [127:0]          wr_word;
	logic                  done;
	int                    num_errors = 0;
	int                    checks_done = 0;
	always #50 mclk = ~mclk;
	dcd_ctrl_model ctrl (.kind(kind), .cke(cke), .bank(bank), .addr(addr), .bus(bus));
	dcd_core dut (.mclk(mclk), .rst_n(rst_n), .cmd_in(bus), .wr_beat(wr_beat),
		.lower_byte_write_mask(lower_byte_write_mask), .upper_byte_write_mask(upper_byte_write_mask),
		.rd_word(rd_word), .decoded(dec), .bank_open(bank_open), .power_mode(pm),
		.mode_reg0(mr0), .beat_col(beat_col), .rd_beat(rd_beat), .wr_word(wr_word),
		.wr_byte_en(wr_be), .word_done(done));
	task end_sim;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// One command, then back to no-op so it is sampled only once
	task cmd(input dcd_cmd_t k, input logic [2:0] b, input logic [12:0] a, input logic c);
		@(posedge mclk);
		kind <= k;
		bank <= b;
		addr <= a;
		cke <= c;
		@(posedge mclk);
		kind <= DCD_CMD_NOP;
		#1;
	endtask
	task wait_done;
		int n;
		n = 0;
		while (done !== 1'b1) begin
			@(posedge mclk);
			#1;
			n++;
			if (n > 30) begin
				num_errors++;
				end_sim();
			end
		end
	endtask
	task t_modes;
		cmd(DCD_CMD_MRS, 0, 13'h0001, 1);
		`CHK("mode_reg0", 13'h0001, mr0)
		cmd(DCD_CMD_NOP, 0, 0, 1);
		`CHK("nop", DCD_CMD_NOP, dec.cmd)
		cmd(DCD_CMD_DES, 7, 13'h1FFF, 1);
		`CHK("des", DCD_CMD_DES, dec.cmd)
		cmd(DCD_CMD_REF, 0, 0, 1);
		`CHK("ref", DCD_CMD_REF, dec.cmd)
		cmd(DCD_CMD_ZQL, 0, 13'h0400, 1);
		`CHK("zql", DCD_CMD_ZQL, dec.cmd)
		cmd(DCD_CMD_ZQL, 0, 0, 1);
		`CHK("zqs", DCD_CMD_ZQS, dec.cmd)
	endtask
	task t_write;
		cmd(DCD_CMD_ACT, 3, 13'h1ABC, 1);
		`CHK("open", 8'h08, bank_open)
		`CHK("row", 13'h1ABC, dec.row)
		cmd(DCD_CMD_ACT, 3, 0, 1);
		`CHK("reopen", 1'b1, dec.illegal)
		@(posedge mclk);
		wr_beat <= 16'h1111;
		cmd(DCD_CMD_WR, 3, 13'h1000, 1);
		`CHK("wr", DCD_CMD_WR, dec.cmd)
		`CHK("wr bl8", 1'b0, dec.chop4)
		for (int i = 1; i < 8; i++) begin
			@(posedge mclk);
			wr_beat <= 16'(16'h1111 * (i + 1));
			lower_byte_write_mask <= (i == 1);
			upper_byte_write_mask <= (i == 2);
		end
		wait_done();
		`CHK("byte_en", 16'hFFDB, wr_be)
		`CHK("beat7", 16'h8888, wr_word[127:112])
		`CHK("beat0", 16'h1111, wr_word[15:0])
		`CHK("beat1", 16'h2200, wr_word[31:16])
		`CHK("beat2", 16'h0033, wr_word[47:32])
		`CHK("wr col", 10'h007, beat_col)
	endtask
	task t_read;
		@(posedge mclk);
		rd_word <= 128'h7777_6666_5555_4444_3333_2222_1111_0000;
		cmd(DCD_CMD_RD, 3, 13'h0400, 1);
		`CHK("rd", DCD_CMD_RD, dec.cmd)
		`CHK("chop", 1'b1, dec.chop4)
		`CHK("ap", 1'b1, dec.auto_pre)
		cmd(DCD_CMD_RD, 3, 13'h0400, 1);
		`CHK("rd busy", 1'b1, dec.illegal)
		wait_done();
		`CHK("rd last", 16'h3333, rd_beat)
		`CHK("rd col", 10'h003, beat_col)
		repeat (2) @(posedge mclk);
		#1;
		`CHK("ap close", 8'h00, bank_open)
	endtask
	task t_refuse;
		cmd(DCD_CMD_RD, 5, 0, 1);
		`CHK("rd closed", 1'b1, dec.illegal)
		cmd(DCD_CMD_ACT, 5, 0, 1);
		cmd(DCD_CMD_ACT, 6, 0, 1);
		cmd(DCD_CMD_REF, 0, 0, 1);
		`CHK("ref busy", 1'b1, dec.illegal)
		cmd(DCD_CMD_PRE, 5, 0, 1);
		`CHK("pre one", 8'h40, bank_open)
		cmd(DCD_CMD_PRE, 0, 13'h0400, 1);
		`CHK("pre all", 8'h00, bank_open)
	endtask
	task t_power;
		cmd(DCD_CMD_NOP, 0, 0, 0);
		`CHK("pde", DCD_PM_PDN, pm)
		`CHK("pde cmd", DCD_CMD_PDE, dec.cmd)
		cmd(DCD_CMD_NOP, 0, 0, 1);
		`CHK("pdx", DCD_CMD_PDX, dec.cmd)
		cmd(DCD_CMD_REF, 0, 0, 0);
		`CHK("sre", DCD_PM_SREF, pm)
		cmd(DCD_CMD_DES, 0, 0, 1);
		`CHK("srx", DCD_PM_ON, pm)
		`CHK("srx cmd", DCD_CMD_SRX, dec.cmd)
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1;
		#1;
		`CHK("rst open", 8'h00, bank_open)
		`CHK("rst pm", DCD_PM_ON, pm)
		// Mode set first, no-op gaps, activate before access
		t_modes();
		t_write();
		t_read();
		t_refuse();
		t_power();
		end_sim();
	end
endmodule
